// *** serdes_tx_pkg.sv ***
// shared constants, types and behaviour notes for the serializer transmit channel
// Notes on behaviour
// RQ1: serialization factor fixed at build, three to ten
// RQ2: capture parallel word into load register first
// RQ3: shift captured word out on serial clock
// RQ4: most significant bit goes out first
// RQ5: load register enters shifter only on strobe
// RQ6: bypass gives double rate or single rate
// RQ7: two output registers, each rate set independently
// RQ8: single rate: one bit, direct or registered
// RQ9: double rate: two bits, clocked output register
// RQ10: bypass ignores serial clock strobe entirely
// RQ11: reset clears registers, output low until load; only serializer mode holds it low, bypass outputs follow their data
package serdes_tx_pkg;

   localparam int unsigned FACTOR_MIN   = 3;        // narrowest word
   localparam int unsigned FACTOR_MAX   = 10;       // widest word
   localparam int unsigned FACTOR_DFLT  = 10;       // build-time default
   localparam int unsigned FIFO_DEPTH   = 8;        // words of buffering
   localparam int unsigned FIFO_PTR_W   = 3;        // index width for the fifo
   localparam logic [9:0]  WORD_RST     = 10'h000;  // load and shift reset value
   localparam logic        LINE_RST     = 1'b0;     // serial line level at reset
   localparam logic        RATE_SDR     = 1'b0;     // per-register rate select: single
   localparam logic        RATE_DDR     = 1'b1;     // per-register rate select: double

   // operating mode of the channel, one-hot
   typedef enum logic [3:0] {
      MODE_SERDES     = 4'h1,   // full serializer
      MODE_SDR_DIRECT = 4'h2,   // bypass, single rate, unregistered
      MODE_SDR_REG    = 4'h4,   // bypass, single rate, registered
      MODE_DDR        = 4'h8    // bypass, double rate
   } tx_mode_type;

   // parallel word from core logic
   typedef struct packed {
      logic [FACTOR_MAX-1:0] bits;
   } tx_word_type;

   // differential output pair
   typedef struct packed {
      logic p;
      logic n;
   } diff_pair_type;

endpackage : serdes_tx_pkg

// *** differential_serializer_tx.sv ***
// word fifo and serializer transmit channel with output-element bypass
`timescale 1ns/1ps

// small flip-flop fifo, valid/ready on both sides
module word_fifo #(
   parameter int unsigned WIDTH = 10,
   parameter int unsigned DEPTH = 8,
   parameter int unsigned PTR_W = 3
) (
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   logic [WIDTH-1:0] mem_q [DEPTH];   // storage, indexed by pointer
   logic [PTR_W-1:0] wr_q;            // write index
   logic [PTR_W-1:0] rd_q;            // read index
   logic [PTR_W:0]   cnt_q;           // occupancy, one bit wider than pointers
   logic             push;
   logic             pop;

   // full and empty come straight from the count, so they never lie
   // the count is one bit wider than the pointers, so compare at that width
   assign in_ready  = (cnt_q != (PTR_W+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // storage write
   always_ff @(posedge mclk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // pointers and count
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == PTR_W'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == PTR_W'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule : word_fifo

// serializer channel top
module differential_serializer_tx #(
   parameter int unsigned FACTOR = serdes_tx_pkg::FACTOR_DFLT // RQ1
) (
   input  wire logic                        mclk,
   input  wire logic                        sys_rst,
   input  serdes_tx_pkg::tx_mode_type       mode,
   input  wire logic                        load_en,
   input  serdes_tx_pkg::tx_word_type       word_data,
   input  wire logic                        word_valid,
   output logic                             word_ready,
   input  wire logic                        sdr_d,
   input  wire logic [1:0]                  ddr_d,
   input  wire logic [1:0]                  reg_rate,
   output serdes_tx_pkg::diff_pair_type     tx_pair,
   output logic                             line_active
);
   localparam int unsigned W = serdes_tx_pkg::FACTOR_MAX;

   logic [W-1:0] fifo_data;     // head of buffer
   logic         fifo_valid;    // head present
   logic         fifo_pop;      // load register takes head
   logic [W-1:0] load_q;        // load register
   logic         load_vld_q;    // load register holds a word
   logic [W-1:0] shift_q;       // shift register
   logic         ser_q;         // serializer output flop
   logic         started_q;     // first strobe seen since reset
   logic [1:0]   oreg_q;        // the two output-element data registers
   logic         phase_q;       // double-rate half select
   logic         byp_q;         // registered bypass output
   logic         is_serdes;
   logic         xfer;          // load register moves into shifter
   logic         out_bit;

   assign is_serdes = (mode == serdes_tx_pkg::MODE_SERDES);
   assign xfer      = is_serdes && load_en; // RQ5 RQ10

   // buffer between core and load register; it fills when strobes stop
   word_fifo #(
      .WIDTH (W),
      .DEPTH (serdes_tx_pkg::FIFO_DEPTH),
      .PTR_W (serdes_tx_pkg::FIFO_PTR_W)
   ) u_fifo (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .in_data   (word_data.bits),
      .in_valid  (word_valid),
      .in_ready  (word_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop)
   );

   // refill when empty or when the current word leaves this very cycle
   assign fifo_pop = is_serdes && (!load_vld_q || xfer);

   // load register capture
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         load_q     <= serdes_tx_pkg::WORD_RST; // RQ11
         load_vld_q <= 1'b0;
      end else if (fifo_pop) begin
         load_q     <= fifo_data;               // RQ2
         load_vld_q <= fifo_valid;
      end
   end

   // shift register: parallel load on strobe, else shift toward msb in serializer mode, hold in bypass
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         shift_q <= serdes_tx_pkg::WORD_RST;                  // RQ11
         ser_q   <= serdes_tx_pkg::LINE_RST;
      end else if (xfer) begin
         // an empty load register sends an idle all-zero word
         ser_q   <= load_vld_q ? load_q[FACTOR-1] : 1'b0;     // RQ4
         shift_q <= load_vld_q ? (load_q << 1) : '0;          // RQ3
      end else if (is_serdes) begin
         ser_q   <= shift_q[FACTOR-1];                        // RQ3 RQ4
         shift_q <= shift_q << 1;
      end
   end

   // in serializer mode the line stays low until the first strobe after reset
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         started_q <= 1'b0;                                   // RQ11
      end else if (xfer) begin
         started_q <= 1'b1;
      end
   end

   // double-rate half select toggles every cycle
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         phase_q <= 1'b0;
      end else begin
         phase_q <= ~phase_q;
      end
   end

   // output-element registers: each single or double rate on its own
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         oreg_q <= 2'h0;
      end else begin
         for (int k = 0; k < 2; k++) begin
            // double rate captures on the pair boundary only
            if (reg_rate[k] == serdes_tx_pkg::RATE_SDR || !phase_q) begin // RQ7
               oreg_q[k] <= ddr_d[k];                                    // RQ9
            end
         end
      end
   end

   // registered single-rate output flop
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         byp_q <= serdes_tx_pkg::LINE_RST;
      end else begin
         byp_q <= sdr_d;                                      // RQ8
      end
   end

   // output select; the direct path has no flop by design
   always_comb begin
      case (mode)
         serdes_tx_pkg::MODE_SDR_DIRECT: out_bit = sdr_d;              // RQ6 RQ8
         serdes_tx_pkg::MODE_SDR_REG:    out_bit = byp_q;              // RQ8
         serdes_tx_pkg::MODE_DDR:        out_bit = oreg_q[phase_q];    // RQ6 RQ9
         default:                        out_bit = started_q & ser_q;  // RQ11
      endcase
   end

   // one driver for the whole pair keeps the legs complementary
   assign tx_pair     = '{p: out_bit, n: ~out_bit};
   assign line_active = !is_serdes || started_q;

   // ---- checks ----
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence seq_strobe_with_word;
      is_serdes && load_en && load_vld_q;
   endsequence

   sequence seq_ddr_pair;
      (mode == serdes_tx_pkg::MODE_DDR) && !phase_q && (reg_rate == 2'h3);
   endsequence

   AST_FACTOR_RANGE: assert property ( // RQ1
      (FACTOR >= serdes_tx_pkg::FACTOR_MIN) && (FACTOR <= serdes_tx_pkg::FACTOR_MAX))
      else $error("factor outside three to ten");

   AST_LOAD_CAPTURE: assert property ( // RQ2
      is_serdes && !load_vld_q && fifo_valid |=> load_vld_q)
      else $error("load register missed a waiting word");

   AST_MSB_FIRST: assert property ( // RQ4
      seq_strobe_with_word |=> tx_pair.p == $past(load_q[FACTOR-1]))
      else $error("first bit is not the msb");

   AST_SECOND_BIT: assert property ( // RQ3
      seq_strobe_with_word ##1 (is_serdes && !load_en)
      |=> tx_pair.p == $past(load_q[FACTOR-2], 2))
      else $error("second bit out of order");

   AST_NO_LOAD_WITHOUT_STROBE: assert property ( // RQ5
      is_serdes && !load_en |=> shift_q == ($past(shift_q) << 1))
      else $error("shifter loaded without strobe");

   AST_BYPASS_FROZEN: assert property ( // RQ10
      !is_serdes |=> $stable(shift_q) && $stable(started_q))
      else $error("serializer moved in bypass");

   AST_SDR_DIRECT: assert property ( // RQ8
      mode == serdes_tx_pkg::MODE_SDR_DIRECT |-> tx_pair.p == sdr_d && tx_pair.n == ~sdr_d)
      else $error("direct path not passed through");

   AST_SDR_REG: assert property ( // RQ8
      mode == serdes_tx_pkg::MODE_SDR_REG ##1 mode == serdes_tx_pkg::MODE_SDR_REG
      |-> tx_pair.p == $past(sdr_d))
      else $error("registered path not one cycle late");

   AST_DDR_PAIR: assert property ( // RQ9
      seq_ddr_pair ##1 (mode == serdes_tx_pkg::MODE_DDR && reg_rate == 2'h3)
      |-> tx_pair.p == $past(ddr_d[1]) ##1 tx_pair.p == $past(ddr_d[0], 2))
      else $error("double-rate pair not sent high then low");

   AST_LOW_UNTIL_STROBE: assert property ( // RQ11
      is_serdes && !started_q |-> tx_pair.p == 1'b0)
      else $error("line not low before first strobe");
endmodule : differential_serializer_tx

// *** serial_rx_model.sv ***
// far-end receiver model that rebuilds serial words from the line
`timescale 1ns/1ps
module serial_rx_model #(
   parameter int unsigned FACTOR = 5 // bits per word
) (
   input  wire logic                    mclk,
   input  serdes_tx_pkg::diff_pair_type rx_pair,
   output logic [FACTOR-1:0]            rx_word,
   output logic                         pair_bad
);
   initial pair_bad = 1'b0; // sticky, so no reset is needed
   // first bit in ends up on top, so msb-first lines read straight
   always @(posedge mclk) begin
      rx_word <= {rx_word[FACTOR-2:0], rx_pair.p};
   end
   // legs that match mean the line is not differential
   always @(posedge mclk) begin
      // unknown legs before the first reset edge do not count as a fault
      if (rx_pair.p == rx_pair.n) begin
         pair_bad <= 1'b1;
      end
   end
endmodule : serial_rx_model

// *** differential_serializer_tx_tb_top.sv ***
// self-checking bench for the serializer transmit channel
`timescale 1ns/1ps
module differential_serializer_tx_tb_top;
   localparam int unsigned F = 5; // short word keeps the run brief
   // one ordinary case: word offered and word the receiver rebuilds
   typedef struct packed {
      logic [4:0] din;
      logic [4:0] dout;
   } row_type;
   localparam row_type ROWS [4] = '{'{5'h1b, 5'h1b}, '{5'h04, 5'h04},
                                    '{5'h1f, 5'h1f}, '{5'h10, 5'h10}};
   logic                          mclk;
   logic                          sys_rst;
   serdes_tx_pkg::tx_mode_type    mode;
   logic                          load_en;     // strobe from the clock generator
   serdes_tx_pkg::tx_word_type    word_data;
   logic                          word_valid;
   logic                          word_ready;
   logic                          sdr_d;
   logic [1:0]                    ddr_d;
   logic [1:0]                    reg_rate;
   serdes_tx_pkg::diff_pair_type  tx_pair;
   logic                          line_active;
   logic [F-1:0]                  rx_word;     // word rebuilt far side
   logic                          pair_bad;
   logic                          prev;        // last line level seen
   int                            num_errors;
   int                            check_count;
   int                            i;
   int                            n;

   differential_serializer_tx #(.FACTOR(F)) dut_u (.mclk(mclk), .sys_rst(sys_rst),
      .mode(mode), .load_en(load_en), .word_data(word_data), .word_valid(word_valid),
      .word_ready(word_ready), .sdr_d(sdr_d), .ddr_d(ddr_d), .reg_rate(reg_rate),
      .tx_pair(tx_pair), .line_active(line_active));
   serial_rx_model #(.FACTOR(F)) rx_u (.mclk(mclk), .rx_pair(tx_pair),
      .rx_word(rx_word), .pair_bad(pair_bad));

   // 50 MHz clock
   always #10 mclk = ~mclk;

   // inputs move just after the edge so sampling never races
   task automatic step;
      @(posedge mclk);
      #1;
   endtask : step

   // compare and count
   task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // verdict and end of run
   task automatic end_of_test;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test

   // offer one word; valid stays up so pushes run back to back
   task automatic push(input logic [4:0] w);
      int k;
      word_data.bits = {5'h00, w};
      word_valid = 1'b1;
      for (k = 0; k < 20 && word_ready !== 1'b1; k++) begin
         step;
      end
      if (k == 20) begin
         num_errors++;
         end_of_test;
      end
      step;
   endtask : push

   // one strobe, then a full word of shift cycles
   task automatic strobe;
      load_en = 1'b1;
      step;
      load_en = 1'b0;
      repeat (F) step;
   endtask : strobe

   // hang guard
   initial begin
      repeat (5000) @(posedge mclk);
      num_errors++;
      end_of_test;
   end

   // main sequence
   initial begin
      mclk = 1'b0;
      sys_rst = 1'b1;
      mode = serdes_tx_pkg::MODE_SERDES;
      load_en = 1'b0;
      word_data = '0;
      word_valid = 1'b0;
      sdr_d = 1'b0;
      ddr_d = 2'b00;
      reg_rate = 2'b00;
      num_errors = 0;
      check_count = 0;
      repeat (16) step;
      chk("reset line", 10'h000, {9'h0, tx_pair.p});
      chk("reset ready", 10'h001, {9'h0, word_ready});
      sys_rst = 1'b0;
      // table of ordinary words, queued then serialized
      for (i = 0; i < 4; i++) push(ROWS[i].din);
      word_valid = 1'b0;
      repeat (3) step;
      chk("idle line", 10'h000, {8'h0, line_active, tx_pair.p});
      for (i = 0; i < 4; i++) begin
         strobe;
         chk("serial word", {5'h0, ROWS[i].dout}, {5'h0, rx_word});
      end
      strobe;
      chk("empty word", 10'h000, {5'h0, rx_word});
      // fill until refused: eight in the fifo plus one in the load register
      word_valid = 1'b1;
      for (n = 0; n < 12 && word_ready === 1'b1; n++) begin
         word_data.bits = 10'(n + 1);
         step;
      end
      word_valid = 1'b0;
      chk("fifo fill", 10'h009, 10'(n));
      for (i = 1; i < 10; i++) begin
         strobe;
         chk("drain word", 10'(i), {5'h0, rx_word});
      end
      chk("ready after drain", 10'h001, {9'h0, word_ready});
      // single rate, direct path follows the input at once
      mode = serdes_tx_pkg::MODE_SDR_DIRECT;
      for (i = 0; i < 2; i++) begin
         sdr_d = i[0];
         step;
         chk("sdr direct", {9'h0, i[0]}, {9'h0, tx_pair.p});
      end
      // single rate, registered; a stray strobe must change nothing
      mode = serdes_tx_pkg::MODE_SDR_REG;
      load_en = 1'b1;
      for (i = 0; i < 4; i++) begin
         sdr_d = i[0];
         step;
         chk("sdr reg", {8'h0, 1'b1, i[0]}, {8'h0, line_active, tx_pair.p});
      end
      load_en = 1'b0;
      // double rate: a fixed pair makes the line toggle every cycle
      mode = serdes_tx_pkg::MODE_DDR;
      reg_rate = 2'b11;
      ddr_d = 2'b10;
      sys_rst = 1'b1;
      step;
      sys_rst = 1'b0;
      repeat (3) step;
      for (i = 0; i < 6; i++) begin
         prev = tx_pair.p;
         step;
         chk("ddr toggle", {9'h0, ~prev}, {9'h0, tx_pair.p});
      end
      // mixed rates: only single-rate registers, low or high, refresh on the odd half
      reg_rate = 2'b10;
      ddr_d = 2'b01;
      step;
      chk("ddr mixed lo", 10'h001, {9'h0, tx_pair.p});
      reg_rate = 2'b01;
      ddr_d = 2'b10;
      step;
      chk("ddr mixed first", 10'h001, {9'h0, tx_pair.p});
      ddr_d = 2'b01;
      step;
      chk("ddr mixed hold", 10'h000, {9'h0, tx_pair.p});
      chk("pair legs", 10'h000, {9'h0, pair_bad});
      end_of_test;
   end
endmodule : differential_serializer_tx_tb_top
